// ==== hdl/gdc_counter.sv ====
// Notes on behaviour
// - Divider counts down from the programmed divisor; in pulse modes output is input over divisor.
// - Gate mode 0 ignores the gate and counts from software start.
// - Gate mode 1 counts only while the gate is high after start.
// - Gate mode 2 counts only while the gate is low after start.
// - Gate mode 3 waits after start for a gate rising edge.
// - Gate mode 4 waits after start for a gate falling edge.
// - Source edge 0 counts rising transitions, 1 counts falling transitions.
// - Output mode 0 gives a high pulse of one counted cycle at terminal count.
// - Output mode 1 gives a low pulse of one counted cycle at terminal count.
// - Output mode 2 goes high at terminal count until the next one.
// - Output mode 3 goes low at terminal count until the next one.
// - Pulse modes divide by divisor, toggle modes by twice the divisor.
// - Event mode counts the selected source edges, or timebase ticks when the internal timebase is on.
// - Without internal timebase the source pin clocks the counter, else the timebase.
//
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`default_nettype none
module gdc_counter
    import gdc_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic COUNTER_SOURCE_INPUT,
    input wire logic COUNTER_GATE_INPUT,
    output logic COUNTER_OUTPUT_PIN,
    output logic TERMINAL_COUNT_REACHED
);
    logic [1:0] src_sync;
    logic [1:0] gate_sync;
    logic src_prev;
    logic gate_prev;
    gdc_cfg_t cfg;
    logic [31:0] divisor;
    logic [31:0] count;
    logic [31:0] events;
    logic [7:0] tb_cnt;
    logic tb_tick;
    logic src_tick;
    logic cnt_tick;
    logic gate_ok;
    logic tc_now;
    logic toggle_level;
    logic pulse_active;
    logic acked;
    logic start_cmd;
    logic stop_cmd;
    logic wr_ctrl;
    gdc_state_t state;

    always_ff @(posedge MCLK)
    begin
        src_sync <= {src_sync[0], COUNTER_SOURCE_INPUT};
        gate_sync <= {gate_sync[0], COUNTER_GATE_INPUT};
        src_prev <= src_sync[1];
        gate_prev <= gate_sync[1];
        if (RST)
        begin
            src_sync <= 2'h0;
            gate_sync <= 2'h0;
            src_prev <= 1'b0;
            gate_prev <= 1'b0;
        end
    end

    // One-cycle timebase tick derived from the system clock.
    always_ff @(posedge MCLK)
    begin
        if (RST || tb_cnt == TB_CYCLES[7:0] - 8'h01)
            tb_cnt <= 8'h00;
        else
            tb_cnt <= tb_cnt + 8'h01;
    end
    assign tb_tick = (tb_cnt == TB_CYCLES[7:0] - 8'h01);

    // Selected edge of the source pin.
    assign src_tick = cfg.source_edge ? (src_prev & ~src_sync[1])
                                      : (~src_prev & src_sync[1]);
    assign cnt_tick = cfg.internal_tb ? tb_tick : src_tick;

    always_comb
    begin
        unique case (cfg.gate_mode)
            GATE_HIGH: gate_ok = gate_sync[1];
            GATE_LOW: gate_ok = ~gate_sync[1];
            default: gate_ok = 1'b1;
        endcase
    end

    // Bus access: one wait cycle, then acknowledge from a flip-flop.
    always_ff @(posedge MCLK)
    begin
        if (RST)
            AVS_WAITREQUEST <= 1'b1;
        else
            AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
    end
    assign acked = !AVS_WAITREQUEST;
    assign wr_ctrl = AVS_WRITE && acked && AVS_ADDRESS == OFS_CTRL;
    assign start_cmd = wr_ctrl && AVS_WRITEDATA[CTRL_START_POS];
    assign stop_cmd = wr_ctrl && AVS_WRITEDATA[CTRL_STOP_POS];

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            cfg <= '0;
            divisor <= DIVISOR_RESET;
        end
        else if (AVS_WRITE && acked)
        begin
            if (AVS_ADDRESS == OFS_CTRL && state == GDC_IDLE)
            begin
                cfg.gate_mode <= AVS_WRITEDATA[CTRL_GATE_POS +: 3];
                cfg.source_edge <= AVS_WRITEDATA[CTRL_EDGE_POS];
                cfg.out_mode <= AVS_WRITEDATA[CTRL_OUT_POS +: 2];
                cfg.internal_tb <= AVS_WRITEDATA[CTRL_INTTB_POS];
                cfg.event_mode <= AVS_WRITEDATA[CTRL_EVENT_POS];
            end
            if (AVS_ADDRESS == OFS_DIVISOR && state == GDC_IDLE)
                divisor <= (AVS_WRITEDATA == 32'h0) ? 32'h1 : AVS_WRITEDATA;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
            AVS_READDATA <= 32'h0;
        else
        begin
            unique case (AVS_ADDRESS)
                OFS_CTRL: AVS_READDATA <= {24'h0, cfg.event_mode, cfg.internal_tb,
                                           cfg.out_mode, cfg.source_edge, cfg.gate_mode};
                OFS_DIVISOR: AVS_READDATA <= divisor;
                OFS_STATUS: AVS_READDATA <= {29'h0, COUNTER_OUTPUT_PIN, state};
                OFS_COUNT: AVS_READDATA <= count;
                OFS_EVENTS: AVS_READDATA <= events;
                default: AVS_READDATA <= 32'h0;
            endcase
        end
    end

    // Start, arm and stop sequencing.
    always_ff @(posedge MCLK)
    begin
        if (RST || stop_cmd)
            state <= GDC_IDLE;
        else
        begin
            unique case (state)
                GDC_IDLE:
                    if (start_cmd)
                        state <= (cfg.gate_mode == GATE_RISE || cfg.gate_mode == GATE_FALL)
                                 ? GDC_ARMED : GDC_RUN;
                GDC_ARMED:
                    if ((cfg.gate_mode == GATE_RISE && !gate_prev && gate_sync[1])
                        || (cfg.gate_mode == GATE_FALL && gate_prev && !gate_sync[1]))
                        state <= GDC_RUN;
                GDC_RUN: state <= GDC_RUN;
                default: state <= GDC_IDLE;
            endcase
        end
    end

    assign tc_now = state == GDC_RUN && gate_ok && cnt_tick && !cfg.event_mode
                    && count == 32'h1;

    // Down count with reload; events count up.
    always_ff @(posedge MCLK)
    begin
        if (RST || state == GDC_IDLE)
        begin
            count <= divisor;
            events <= (RST || start_cmd) ? 32'h0 : events;
        end
        else if (state == GDC_RUN && gate_ok && cnt_tick)
        begin
            if (cfg.event_mode)
                events <= events + 32'h1;
            else if (count == 32'h1)
                count <= divisor;
            else
                count <= count - 32'h1;
        end
    end

    // Pulse lasts until the next counted cycle.
    always_ff @(posedge MCLK)
    begin
        if (RST || state == GDC_IDLE)
            pulse_active <= 1'b0;
        else if (tc_now)
            pulse_active <= 1'b1;
        else if (cnt_tick)
            pulse_active <= 1'b0;
    end

    always_ff @(posedge MCLK)
    begin
        if (RST || state == GDC_IDLE)
            toggle_level <= 1'b0;
        else if (tc_now)
            toggle_level <= ~toggle_level;
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            COUNTER_OUTPUT_PIN <= 1'b0;
            TERMINAL_COUNT_REACHED <= 1'b0;
        end
        else
        begin
            TERMINAL_COUNT_REACHED <= tc_now;
            unique case (cfg.out_mode)
                OUT_PULSE_HI: COUNTER_OUTPUT_PIN <= pulse_active;
                OUT_PULSE_LO: COUNTER_OUTPUT_PIN <= ~pulse_active;
                OUT_TOGGLE_HI: COUNTER_OUTPUT_PIN <= toggle_level;
                OUT_TOGGLE_LO: COUNTER_OUTPUT_PIN <= ~toggle_level;
            endcase
        end
    end

    property p_wait_one;
        @(posedge MCLK) disable iff (RST)
        $rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("Bus answer not after one cycle.");

    property p_reload;
        @(posedge MCLK) disable iff (RST)
        tc_now |=> count == divisor;
    endproperty
    a_reload: assert property (p_reload) else $error("Divisor not reloaded.");

    property p_down;
        @(posedge MCLK) disable iff (RST)
        (state == GDC_RUN && gate_ok && cnt_tick && !cfg.event_mode && count > 32'h1)
        |=> count == $past(count) - 32'h1;
    endproperty
    a_down: assert property (p_down) else $error("Count did not step down.");

    property p_gate_hold;
        @(posedge MCLK) disable iff (RST)
        (state == GDC_RUN && cfg.gate_mode == GATE_HIGH && !gate_sync[1]) |=> $stable(count);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("Counted with gate low.");

    property p_gate_low_hold;
        @(posedge MCLK) disable iff (RST)
        (state == GDC_RUN && cfg.gate_mode == GATE_LOW && gate_sync[1]) |=> $stable(count);
    endproperty
    a_gate_low_hold: assert property (p_gate_low_hold) else $error("Counted with gate high.");

    property p_armed_wait;
        @(posedge MCLK) disable iff (RST)
        (state == GDC_ARMED && cfg.gate_mode == GATE_RISE && !(!gate_prev && gate_sync[1])
         && !stop_cmd) |=> state == GDC_ARMED;
    endproperty
    a_armed_wait: assert property (p_armed_wait) else $error("Left arm without gate edge.");

    property p_start_free;
        @(posedge MCLK) disable iff (RST)
        (state == GDC_IDLE && start_cmd && cfg.gate_mode == GATE_NONE) |=> state == GDC_RUN;
    endproperty
    a_start_free: assert property (p_start_free) else $error("Ungated start failed.");

    property p_pulse_hi;
        @(posedge MCLK) disable iff (RST)
        (tc_now && cfg.out_mode == OUT_PULSE_HI && !stop_cmd) |=> ##1 COUNTER_OUTPUT_PIN;
    endproperty
    a_pulse_hi: assert property (p_pulse_hi) else $error("No high pulse.");

    property p_toggle;
        @(posedge MCLK) disable iff (RST)
        (tc_now && cfg.out_mode == OUT_TOGGLE_HI && !stop_cmd)
        |=> ##1 COUNTER_OUTPUT_PIN != $past(COUNTER_OUTPUT_PIN, 1);
    endproperty
    a_toggle: assert property (p_toggle) else $error("Toggle missed.");

    property p_pulse_lo;
        @(posedge MCLK) disable iff (RST)
        (tc_now && cfg.out_mode == OUT_PULSE_LO && !stop_cmd) |=> ##1 !COUNTER_OUTPUT_PIN;
    endproperty
    a_pulse_lo: assert property (p_pulse_lo) else $error("No low pulse.");

    property p_toggle_lo;
        @(posedge MCLK) disable iff (RST)
        (tc_now && cfg.out_mode == OUT_TOGGLE_LO && !stop_cmd)
        |=> ##1 COUNTER_OUTPUT_PIN != $past(COUNTER_OUTPUT_PIN, 1);
    endproperty
    a_toggle_lo: assert property (p_toggle_lo) else $error("Low toggle missed.");

    property p_armed_fall;
        @(posedge MCLK) disable iff (RST)
        (state == GDC_ARMED && cfg.gate_mode == GATE_FALL && !(gate_prev && !gate_sync[1])
         && !stop_cmd) |=> state == GDC_ARMED;
    endproperty
    a_armed_fall: assert property (p_armed_fall) else $error("Left arm without fall.");

    property p_start_gated;
        @(posedge MCLK) disable iff (RST)
        (state == GDC_IDLE && start_cmd && !stop_cmd
         && (cfg.gate_mode == GATE_RISE || cfg.gate_mode == GATE_FALL))
        |=> state == GDC_ARMED;
    endproperty
    a_start_gated: assert property (p_start_gated) else $error("Edge start not armed.");

    property p_tc_single;
        @(posedge MCLK) disable iff (RST)
        TERMINAL_COUNT_REACHED |=> !TERMINAL_COUNT_REACHED;
    endproperty
    a_tc_single: assert property (p_tc_single) else $error("Terminal count too long.");

    property p_event_count;
        @(posedge MCLK) disable iff (RST)
        (state == GDC_RUN && cfg.event_mode && gate_ok && cnt_tick)
        |=> events == $past(events) + 32'h1;
    endproperty
    a_event_count: assert property (p_event_count) else $error("Event not counted.");

    property p_timebase;
        @(posedge MCLK) disable iff (RST)
        (state == GDC_RUN && cfg.internal_tb && !tb_tick) |=> $stable(count) && $stable(events);
    endproperty
    a_timebase: assert property (p_timebase) else $error("Counted off timebase.");

    property p_source_edge;
        @(posedge MCLK) disable iff (RST)
        (state == GDC_RUN && !cfg.internal_tb && !src_tick) |=> $stable(count) && $stable(events);
    endproperty
    a_source_edge: assert property (p_source_edge) else $error("Counted off edge.");

    c_tc: cover property (@(posedge MCLK) disable iff (RST) tc_now);
    c_armed: cover property (@(posedge MCLK) disable iff (RST) state == GDC_ARMED ##1
                             state == GDC_RUN);
    c_event: cover property (@(posedge MCLK) disable iff (RST) cfg.event_mode && events > 32'h2);
    c_toggle: cover property (@(posedge MCLK) disable iff (RST) tc_now && cfg.out_mode[1]);
endmodule // gdc_counter
`default_nettype wire

// ==== hdl/gdc_pkg.sv ====
`default_nettype none
package gdc_pkg;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_DIVISOR = 4'h1;
    localparam logic [3:0] OFS_STATUS = 4'h2;
    localparam logic [3:0] OFS_COUNT = 4'h3;
    localparam logic [3:0] OFS_EVENTS = 4'h4;
    localparam int CTRL_GATE_POS = 0;
    localparam int CTRL_EDGE_POS = 3;
    localparam int CTRL_OUT_POS = 4;
    localparam int CTRL_INTTB_POS = 6;
    localparam int CTRL_EVENT_POS = 7;
    localparam int CTRL_START_POS = 8;
    localparam int CTRL_STOP_POS = 9;
    localparam logic [31:0] DIVISOR_RESET = 32'h00000002;
    localparam logic [31:0] TB_DIV_RESET = 32'h00000019;
    localparam logic [2:0] GATE_NONE = 3'h0;
    localparam logic [2:0] GATE_HIGH = 3'h1;
    localparam logic [2:0] GATE_LOW = 3'h2;
    localparam logic [2:0] GATE_RISE = 3'h3;
    localparam logic [2:0] GATE_FALL = 3'h4;
    localparam logic [1:0] OUT_PULSE_HI = 2'h0;
    localparam logic [1:0] OUT_PULSE_LO = 2'h1;
    localparam logic [1:0] OUT_TOGGLE_HI = 2'h2;
    localparam logic [1:0] OUT_TOGGLE_LO = 2'h3;
    localparam int TB_FREQ_HZ = 1000000;
    localparam int CLK_HZ = 25000000;
    localparam int TB_CYCLES = CLK_HZ / TB_FREQ_HZ;
    typedef enum logic [1:0] {
        GDC_IDLE = 2'b00,
        GDC_ARMED = 2'b01,
        GDC_RUN = 2'b11
    } gdc_state_t;
    typedef struct packed {
        logic [2:0] gate_mode;
        logic source_edge;
        logic [1:0] out_mode;
        logic internal_tb;
        logic event_mode;
    } gdc_cfg_t;
endpackage
`default_nettype wire

// ==== tb/gdc_pin_model.sv ====
`default_nettype none
module gdc_pin_model (
    input wire logic clk,
    input wire logic run,
    input wire logic man,
    input wire logic gate_level,
    output logic src,
    output logic gate
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ph;
    // The source toggles every four clocks in a burst and follows man between bursts.
    always_ff @(posedge clk)
    begin
        ph <= run ? ph + 2'h1 : 2'h0;
        src <= run ? (ph == 2'h3 ? ~src : src) : man;
        gate <= gate_level;
    end
endmodule // gdc_pin_model
`default_nettype wire

// ==== tb/test_gated_down_counter_divider.sv ====
`default_nettype none
module test_gated_down_counter_divider import gdc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic src;
    logic gate;
    logic outp;
    logic tc;
    logic run = 1'b0;
    logic man = 1'b0;
    logic gl = 1'b0;
    logic [31:0] q;
    int seed = 79293;
    int n_mismatch = 0;
    int comparisons = 0;
    always #20 mclk = ~mclk;
    gdc_counter u_dut (
        .MCLK(mclk),
        .RST(rst),
        .AVS_ADDRESS(addr),
        .AVS_READ(rd_en),
        .AVS_WRITE(wr_en),
        .AVS_WRITEDATA(wdata),
        .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq),
        .COUNTER_SOURCE_INPUT(src),
        .COUNTER_GATE_INPUT(gate),
        .COUNTER_OUTPUT_PIN(outp),
        .TERMINAL_COUNT_REACHED(tc)
    );
    gdc_pin_model u_pins (
        .clk(mclk),
        .run(run),
        .man(man),
        .gate_level(gl),
        .src(src),
        .gate(gate)
    );
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic tmo;
        n_mismatch++;
        $display("wait timed out");
        summarize();
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %0d seen %0d", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k = 0;
        addr <= a;
        wdata <= d;
        wr_en <= w;
        rd_en <= ~w;
        @(posedge mclk);
        while (waitreq !== 1'b0)
        begin
            k++;
            if (k > 40) tmo();
            @(posedge mclk);
        end
        q = rdata;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic setup(input int g, input int e, input int o, input int t, input int v,
        input int d);
        logic [31:0] c;
        c = 32'(g) | 32'(e) << CTRL_EDGE_POS | 32'(o) << CTRL_OUT_POS;
        c = c | 32'(t) << CTRL_INTTB_POS | 32'(v) << CTRL_EVENT_POS;
        bus(1'b1, OFS_CTRL, 32'h1 << CTRL_STOP_POS);
        bus(1'b1, OFS_CTRL, c);
        bus(1'b1, OFS_DIVISOR, 32'(d));
        bus(1'b1, OFS_CTRL, c | 32'h1 << CTRL_START_POS);
    endtask
    task automatic burst(input int n);
        run <= 1'b1;
        repeat (8 * n) @(posedge mclk);
        run <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
    // Measures one output period between the second and third rising edges.
    task automatic meas(input int sp, input int d, input int o);
        int t = 0;
        int r = 0;
        int per = 0;
        int hi = 0;
        int np = 0;
        logic p;
        p = outp;
        while (r < 3)
        begin
            @(posedge mclk);
            t++;
            if (t > 4000) tmo();
            if (r == 2) per++;
            if (r == 2 && outp === 1'b1) hi++;
            if (r == 2 && tc === 1'b1) np++;
            if (outp === 1'b1 && p === 1'b0) r++;
            p = outp;
        end
        chk("period", o < 2 ? sp * d : 2 * sp * d, per);
        chk("high time", o == 0 ? sp : (o == 1 ? sp * d - sp : sp * d), hi);
        chk("terminal counts", o < 2 ? 1 : 2, np);
    endtask
    initial
    begin
        int d;
        int n;
        int g;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rdc("divisor", OFS_DIVISOR, DIVISOR_RESET);
        rdc("status", OFS_STATUS, 32'h0);
        rdc("unmapped", 4'hf, 32'h0);
        $display("test reset done");
        for (int m = 0; m < 8; m++)
        begin
            d = 2 + $unsigned($random(seed)) % 8;
            setup(0, 0, m % 4, m / 4, 0, d);
            run <= (m < 4);
            meas(m < 4 ? 8 : TB_CYCLES, d, m % 4);
            run <= 1'b0;
        end
        $display("test output modes done");
        for (int e = 0; e < 2; e++)
        begin
            setup(0, e, 0, 0, 0, 100);
            man <= 1'b1;
            repeat (8) @(posedge mclk);
            rdc("count after rise", OFS_COUNT, e ? 32'h64 : 32'h63);
            man <= 1'b0;
            repeat (8) @(posedge mclk);
            rdc("count after fall", OFS_COUNT, 32'h63);
        end
        $display("test source edge done");
        for (g = 0; g < 5; g++)
        begin
            gl <= (g == 2 || g == 4);
            repeat (8) @(posedge mclk);
            setup(g, 0, 0, 0, 0, 100);
            rdc("control", OFS_CTRL, 32'(g));
            burst(6);
            rdc("count gate shut", OFS_COUNT, g ? 32'h64 : 32'h5e);
            gl <= !(g == 2 || g == 4);
            repeat (8) @(posedge mclk);
            burst(6);
            rdc("count gate open", OFS_COUNT, g ? 32'h5e : 32'h58);
        end
        $display("test gate modes done");
        n = 3 + $unsigned($random(seed)) % 8;
        setup(0, 0, 0, 0, 1, 100);
        rdc("status running", OFS_STATUS, 32'h3);
        burst(n);
        rdc("events", OFS_EVENTS, 32'(n));
        $display("test events done");
        summarize();
    end
endmodule // test_gated_down_counter_divider
`default_nettype wire
